// File: rtl/cvsc_pkg.sv
package cvsc_pkg;

    localparam logic [4:0]  REG_ADDR_CONFIG  = 5'h07;
    localparam logic [15:0] CONFIG_RESET     = 16'h0000;

    localparam int          CAP_EN_POS       = 15;
    localparam int          TIMING_LSB       = 9;
    localparam int          TIMING_W         = 5;
    localparam int          STALL_CNT_LSB    = 6;
    localparam int          STALL_CNT_W      = 3;
    localparam int          SLOT_PTR_LSB     = 4;
    localparam int          AUTO_HOLD_POS    = 3;
    localparam int          CV_W             = 10;

    localparam logic [4:0]  TIMING_AUTO      = 5'h00;
    localparam logic [2:0]  STALL_CNT_ZERO   = 3'h0;
    localparam logic [2:0]  STALL_CNT_ONE    = 3'h1;
    localparam logic [1:0]  SLOT_RESET       = 2'h0;

    typedef enum logic [1:0] {
        CVSC_SLOT_A = 2'h0,
        CVSC_SLOT_B = 2'h1,
        CVSC_SLOT_C = 2'h2,
        CVSC_SLOT_D = 2'h3
    } cvsc_slot_type;

    typedef enum logic [1:0] {
        CVSC_ST_IDLE  = 2'h0,
        CVSC_ST_DELAY = 2'h1,
        CVSC_ST_AUTO  = 2'h2,
        CVSC_ST_DONE  = 2'h3
    } cvsc_state_type;

    typedef struct packed {
        logic                   cap_en;
        logic [TIMING_W-1:0]    timing;
        logic [STALL_CNT_W-1:0] stall_cnt;
        logic                   auto_hold;
    } cvsc_cfg_type;

    typedef struct packed {
        logic                   valid;
        cvsc_slot_type          slot;
        logic [CV_W-1:0]        data;
    } cvsc_sample_type;

endpackage

// File: rtl/cvsc_stall_detect.sv
module cvsc_stall_detect (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rst_n,
    input  wire logic                                 i_enable,
    input  wire cvsc_pkg::cvsc_sample_type            i_sample,
    input  wire logic [cvsc_pkg::CV_W-1:0]            i_lower,
    input  wire logic [cvsc_pkg::CV_W-1:0]            i_upper,
    input  wire logic [cvsc_pkg::STALL_CNT_W-1:0]     i_threshold,
    output logic                                      o_detect
);

    logic [cvsc_pkg::STALL_CNT_W-1:0] run_cnt;
    logic [cvsc_pkg::STALL_CNT_W-1:0] thr_eff;
    logic                             out_of_range;
    logic                             hit;

    // A zero threshold behaves as one so the first bad sample already flags.
    assign thr_eff = (i_threshold == cvsc_pkg::STALL_CNT_ZERO) ?
                     cvsc_pkg::STALL_CNT_ONE : i_threshold; // see R7
    assign out_of_range = (i_sample.data < i_lower) || (i_sample.data > i_upper); // see R6
    assign hit = i_enable && i_sample.valid && out_of_range &&
                 ((run_cnt + cvsc_pkg::STALL_CNT_ONE) >= thr_eff); // see R5

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_enable) begin
            run_cnt <= cvsc_pkg::STALL_CNT_ZERO;
        end else if (i_sample.valid) begin
            if (!out_of_range || hit) begin
                run_cnt <= cvsc_pkg::STALL_CNT_ZERO; // see R6
            end else begin
                run_cnt <= run_cnt + cvsc_pkg::STALL_CNT_ONE; // see R5
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_detect <= 1'b0;
        end else begin
            o_detect <= hit;
        end
    end

    in_range_restart_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R6
        i_enable && i_sample.valid && !out_of_range |=> run_cnt == cvsc_pkg::STALL_CNT_ZERO)
        else $error("In-range sample did not restart the run count.");

    zero_threshold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R7
        i_enable && i_sample.valid && out_of_range && i_threshold == cvsc_pkg::STALL_CNT_ZERO
        |=> o_detect)
        else $error("Zero threshold did not flag on first bad sample.");

    count_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R5
        o_detect |-> $past(run_cnt) + cvsc_pkg::STALL_CNT_ONE >= $past(thr_eff))
        else $error("Stall flagged before enough consecutive bad samples.");

endmodule

// File: rtl/cvsc_top.sv
// Summary of operation
// R1 - Capture enable one allows coil voltage capture; zero blocks all capture.
// R2 - Sample after the timing field's count of PWM periods from zero step start.
// R3 - Host programs nonzero timing values larger than one PWM period only.
// R4 - Timing field zero samples automatically at the end of the zero step.
// R5 - Stall flag sets after stall count consecutive out-of-range samples.
// R6 - Out of range means outside the limits; in-range sample restarts counting.
// R7 - A stall count of zero behaves exactly like a count of one.
// R8 - Read-only two-bit pointer names the latest updated result slot A to D.
// R9 - With auto hold enabled, a stall sets the hold mode control bit.
// R10 - With auto hold disabled, a stall sets only the stall flag.
// R11 - Reserved bits read zero; writes to reserved and read-only bits are ignored.
module cvsc_top (
    input  wire logic                          I_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_REG_WR,
    input  wire logic                          I_REG_RD,
    input  wire logic [4:0]                    I_REG_ADDR,
    input  wire logic [15:0]                   I_REG_WDATA,
    input  wire logic                          I_PWM_TICK,
    input  wire logic                          I_ZERO_START,
    input  wire logic                          I_ZERO_END,
    input  wire cvsc_pkg::cvsc_sample_type     I_CV_RESULT,
    input  wire logic [cvsc_pkg::CV_W-1:0]     I_LOWER_LIMIT,
    input  wire logic [cvsc_pkg::CV_W-1:0]     I_UPPER_LIMIT,
    input  wire logic                          I_STALL_CLR,
    output logic [15:0]                        O_REG_RDATA,
    output logic                               O_SAMPLE_STROBE,
    output logic                               O_STALL_FLAG,
    output logic                               O_HOLD_SET,
    output logic [1:0]                         O_LATEST_SLOT
);

    cvsc_pkg::cvsc_cfg_type            cfg;
    cvsc_pkg::cvsc_state_type          state;
    cvsc_pkg::cvsc_state_type          next_state;
    logic [cvsc_pkg::TIMING_W-1:0]     pwm_cnt;
    logic [cvsc_pkg::TIMING_W-1:0]     next_pwm_cnt;
    logic                              next_strobe;
    logic                              cfg_wr;
    logic                              stall_detect;
    cvsc_pkg::cvsc_sample_type         sample_gated;
    logic [15:0]                       read_word;

    assign cfg_wr = I_REG_WR && (I_REG_ADDR == cvsc_pkg::REG_ADDR_CONFIG);

    // Only writable fields are stored, so reserved and pointer bits cannot be disturbed.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            cfg <= '0;
        end else if (cfg_wr) begin
            cfg.cap_en    <= I_REG_WDATA[cvsc_pkg::CAP_EN_POS]; // see R11
            cfg.timing    <= I_REG_WDATA[cvsc_pkg::TIMING_LSB +: cvsc_pkg::TIMING_W];
            cfg.stall_cnt <= I_REG_WDATA[cvsc_pkg::STALL_CNT_LSB +: cvsc_pkg::STALL_CNT_W];
            cfg.auto_hold <= I_REG_WDATA[cvsc_pkg::AUTO_HOLD_POS];
        end
    end

    always_comb begin
        read_word = cvsc_pkg::CONFIG_RESET; // see R11
        read_word[cvsc_pkg::CAP_EN_POS] = cfg.cap_en;
        read_word[cvsc_pkg::TIMING_LSB +: cvsc_pkg::TIMING_W] = cfg.timing;
        read_word[cvsc_pkg::STALL_CNT_LSB +: cvsc_pkg::STALL_CNT_W] = cfg.stall_cnt;
        read_word[cvsc_pkg::SLOT_PTR_LSB +: 2] = O_LATEST_SLOT; // see R8
        read_word[cvsc_pkg::AUTO_HOLD_POS] = cfg.auto_hold;
    end

    // Parity in bit 0 is left to the serial layer, so it reads zero here.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= cvsc_pkg::CONFIG_RESET;
        end else if (I_REG_RD && (I_REG_ADDR == cvsc_pkg::REG_ADDR_CONFIG)) begin
            O_REG_RDATA <= read_word;
        end else begin
            O_REG_RDATA <= cvsc_pkg::CONFIG_RESET;
        end
    end

    // A timing of one is not guarded; the host must not program it.
    always_comb begin
        next_state   = state;
        next_pwm_cnt = pwm_cnt;
        next_strobe  = 1'b0;
        case (state)
            cvsc_pkg::CVSC_ST_IDLE: begin
                if (I_ZERO_START) begin
                    next_pwm_cnt = '0;
                    next_state = (cfg.timing == cvsc_pkg::TIMING_AUTO) ?
                                 cvsc_pkg::CVSC_ST_AUTO : cvsc_pkg::CVSC_ST_DELAY; // see R4
                end
            end
            cvsc_pkg::CVSC_ST_DELAY: begin
                if (I_ZERO_END) begin
                    next_state = cvsc_pkg::CVSC_ST_IDLE;
                end else if (I_PWM_TICK) begin
                    next_pwm_cnt = pwm_cnt + 5'h01;
                    if (next_pwm_cnt == cfg.timing) begin
                        next_strobe = 1'b1; // see R2
                        next_state  = cvsc_pkg::CVSC_ST_DONE;
                    end
                end
            end
            cvsc_pkg::CVSC_ST_AUTO: begin
                if (I_ZERO_END) begin
                    next_strobe = 1'b1; // see R4
                    next_state  = cvsc_pkg::CVSC_ST_IDLE;
                end
            end
            cvsc_pkg::CVSC_ST_DONE: begin
                if (I_ZERO_END) begin
                    next_state = cvsc_pkg::CVSC_ST_IDLE;
                end
            end
            default: begin
                next_state = cvsc_pkg::CVSC_ST_IDLE;
            end
        endcase
        if (!cfg.cap_en) begin
            next_state  = cvsc_pkg::CVSC_ST_IDLE; // see R1
            next_strobe = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state   <= cvsc_pkg::CVSC_ST_IDLE;
            pwm_cnt <= '0;
        end else begin
            state   <= next_state;
            pwm_cnt <= next_pwm_cnt;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_SAMPLE_STROBE <= 1'b0;
        end else begin
            O_SAMPLE_STROBE <= next_strobe;
        end
    end

    // Results arriving while capture is off are dropped entirely.
    always_comb begin
        sample_gated = I_CV_RESULT;
        sample_gated.valid = I_CV_RESULT.valid && cfg.cap_en; // see R1
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_LATEST_SLOT <= cvsc_pkg::SLOT_RESET;
        end else if (sample_gated.valid) begin
            O_LATEST_SLOT <= sample_gated.slot; // see R8
        end
    end

    cvsc_stall_detect u_stall (
        .i_clk       (I_CLK),
        .i_rst_n     (I_RST_N),
        .i_enable    (cfg.cap_en),
        .i_sample    (sample_gated),
        .i_lower     (I_LOWER_LIMIT),
        .i_upper     (I_UPPER_LIMIT),
        .i_threshold (cfg.stall_cnt),
        .o_detect    (stall_detect)
    );

    // A detection in the clearing cycle wins so no stall is ever lost.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_STALL_FLAG <= 1'b0;
        end else if (stall_detect) begin
            O_STALL_FLAG <= 1'b1; // see R5
        end else if (I_STALL_CLR) begin
            O_STALL_FLAG <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_HOLD_SET <= 1'b0;
        end else begin
            O_HOLD_SET <= stall_detect && cfg.auto_hold; // see R9 see R10
        end
    end

    sequence delay_last_tick_s;
        state == cvsc_pkg::CVSC_ST_DELAY && cfg.cap_en && !I_ZERO_END && I_PWM_TICK &&
        5'(pwm_cnt + 5'h01) == cfg.timing;
    endsequence

    sequence auto_end_s;
        state == cvsc_pkg::CVSC_ST_AUTO && cfg.cap_en && I_ZERO_END;
    endsequence

    no_capture_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R1
        !cfg.cap_en |=> !O_SAMPLE_STROBE && state == cvsc_pkg::CVSC_ST_IDLE)
        else $error("Sample taken while capture disabled.");

    delay_sample_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R2
        delay_last_tick_s |=> O_SAMPLE_STROBE ##1 !O_SAMPLE_STROBE)
        else $error("Delayed sample missing at programmed period.");

    early_sample_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R2
        O_SAMPLE_STROBE && $past(state) == cvsc_pkg::CVSC_ST_DELAY
        |-> $past(pwm_cnt) + 5'h01 == $past(cfg.timing))
        else $error("Delayed sample at wrong period count.");

    auto_sample_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R4
        auto_end_s |=> O_SAMPLE_STROBE)
        else $error("Automatic sample missing at zero step end.");

    auto_select_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R4
        state == cvsc_pkg::CVSC_ST_IDLE && I_ZERO_START && cfg.cap_en &&
        cfg.timing == cvsc_pkg::TIMING_AUTO |=> state == cvsc_pkg::CVSC_ST_AUTO)
        else $error("Zero timing did not select automatic sampling.");

    stall_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R5
        stall_detect |=> O_STALL_FLAG)
        else $error("Stall detection did not set stall flag.");

    hold_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R9
        stall_detect && cfg.auto_hold |=> O_HOLD_SET && O_STALL_FLAG)
        else $error("Auto hold not requested on stall.");

    hold_kept_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R10
        !(stall_detect && cfg.auto_hold) |=> !O_HOLD_SET)
        else $error("Hold requested without auto hold stall.");

    slot_ptr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R8
        I_CV_RESULT.valid && cfg.cap_en |=> O_LATEST_SLOT == $past(I_CV_RESULT.slot))
        else $error("Latest slot pointer not updated.");

    reserved_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see R11
        O_REG_RDATA[14] == 1'b0 && O_REG_RDATA[2:0] == 3'h0)
        else $error("Reserved bits read nonzero.");

endmodule

// File: tb/cvsc_host_model.sv
module cvsc_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic [4:0]       o_addr,
    output logic [15:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 5'h00;
        o_wdata = 16'h0000;
    end

    // A timing of one is never sent; it is raised to three, as a careful host would.
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= (d[13:9] == 5'h01) ? (d | 16'h0400) : d;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask

    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule

// File: tb/test_coil_voltage_stall_control.sv
module test_coil_voltage_stall_control;
    timeunit 1ns;
    timeprecision 1ns;

    logic                      clk;
    logic                      rst_n;
    logic [3:0]                ev;
    cvsc_pkg::cvsc_sample_type cv;
    logic [9:0]                lim_lo;
    logic [9:0]                lim_hi;
    logic                      wr;
    logic                      rd;
    logic [4:0]                addr;
    logic [15:0]               wdata;
    logic [15:0]               rdata;
    logic                      strobe;
    logic                      flag;
    logic                      hold;
    logic [1:0]                slot;
    logic [1:0]                exp_slot;
    logic [15:0]               rv;
    integer                    seed = 26115;
    int                        errors = 0;
    int                        checks_done = 0;
    int                        cycles = 0;
    int                        n_strobe;
    int                        n_hold;
    longint                    t_strobe;
    longint                    t_flag;
    longint                    t_hold;
    longint                    t_ev;
    longint                    t_cv;

    cvsc_top cvsc_top_i (.I_CLK(clk), .I_RST_N(rst_n), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_PWM_TICK(ev[0]), .I_ZERO_START(ev[1]),
        .I_ZERO_END(ev[2]), .I_CV_RESULT(cv), .I_LOWER_LIMIT(lim_lo), .I_UPPER_LIMIT(lim_hi),
        .I_STALL_CLR(ev[3]), .O_REG_RDATA(rdata), .O_SAMPLE_STROBE(strobe),
        .O_STALL_FLAG(flag), .O_HOLD_SET(hold), .O_LATEST_SLOT(slot));

    cvsc_host_model cvsc_host_model_i (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The ceiling sits far above the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (strobe) begin
            n_strobe++;
            t_strobe = $time;
        end
        if (flag && t_flag < 0) begin
            t_flag = $time;
        end
        if (hold) begin
            n_hold++;
            t_hold = $time;
        end
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_t(input longint got, input longint exp, input string m);
        checks_done++;
        if (got != exp) begin
            errors++;
            $display("mismatch at %0t: %s at %0d not %0d", $time, m, got, exp);
        end
    endtask

    function automatic logic [15:0] cfg(logic c, logic [4:0] n, logic [2:0] k, logic a);
        return {c, 1'b0, n, k, 2'b00, a, 3'b000};
    endfunction

    function automatic int rnd(int m);
        return int'($unsigned($random(seed)) % m);
    endfunction

    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        t_ev = $time;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask

    task automatic send_cv(input logic [9:0] d, input logic en);
        logic [1:0] s;
        s = 2'(rnd(4));
        @(posedge clk);
        cv.valid <= 1'b1;
        cv.slot <= cvsc_pkg::cvsc_slot_type'(s);
        cv.data <= d;
        t_cv = $time;
        @(posedge clk);
        cv.valid <= 1'b0;
        #1;
        if (en) exp_slot = s;
        chk(16'(slot), 16'(exp_slot), "latest slot");
    endtask

    function automatic logic [9:0] outv();
        return rnd(2) ? lim_lo - 10'h001 : lim_hi + 10'h001;
    endfunction

    initial begin
        logic [4:0] tv [7];
        int kk;
        int nt;
        logic cap;
        tv = '{5'h00, 5'h02, 5'h03, 5'h07, 5'h1F, 5'h02, 5'h05};
        rst_n = 1'b0;
        ev = 4'h0;
        cv = '0;
        exp_slot = 2'h0;
        lim_lo = 10'h0FF;
        lim_hi = 10'h300;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cvsc_host_model_i.read_reg(5'h07, rv);
        chk(rv, 16'h0000, "reset value");
        cvsc_host_model_i.write_reg(5'h07, 16'hFFFF);
        cvsc_host_model_i.read_reg(5'h07, rv);
        chk(rv, 16'hBFC8, "writable bits");
        cvsc_host_model_i.write_reg(5'h08, 16'h0000);
        cvsc_host_model_i.read_reg(5'h07, rv);
        chk(rv, 16'hBFC8, "other address write");
        cvsc_host_model_i.read_reg(5'h06, rv);
        chk(rv, 16'h0000, "unmapped read");
        $display("register test done");
        // Entries five and six are capture off and an early end that aborts.
        for (int i = 0; i < 7; i++) begin
            cap = (i != 5);
            nt = (i == 6) ? 3 : ((tv[i] == 5'h00) ? 2 + rnd(3) : int'(tv[i]));
            cvsc_host_model_i.write_reg(5'h07, cfg(cap, tv[i], 3'h1, 1'b0));
            n_strobe = 0;
            pulse(1);
            repeat (nt) begin
                repeat (rnd(3)) @(posedge clk);
                pulse(0);
                t_cv = t_ev;
            end
            repeat (2) @(posedge clk);
            pulse(2);
            repeat (3) @(posedge clk);
            #1;
            chk(16'(n_strobe), 16'(cap && i != 6), "strobe count");
            if (n_strobe == 1) chk_t(t_strobe, (tv[i] == 5'h00 ? t_ev : t_cv) + 80, "strobe");
        end
        $display("sampling test done");
        for (int k = 0; k < 8; k++) begin
            kk = (k == 0) ? 1 : k;
            @(posedge clk);
            lim_lo <= 10'(1 + rnd(255));
            lim_hi <= 10'(768 + rnd(255));
            cvsc_host_model_i.write_reg(5'h07, cfg(1'b1, 5'h00, 3'(k), k[0]));
            pulse(3);
            @(posedge clk);
            #1;
            chk(16'(flag), 16'h0000, "flag cleared");
            t_flag = -1;
            n_hold = 0;
            repeat (kk - 1) send_cv(outv(), 1'b1);
            send_cv(rnd(2) ? lim_lo : lim_hi, 1'b1);
            repeat (kk - 1) send_cv(outv(), 1'b1);
            repeat (3) @(posedge clk);
            chk_t(t_flag, -1, "early flag");
            send_cv(outv(), 1'b1);
            repeat (3) @(posedge clk);
            chk_t(t_flag, t_cv + 120, "stall flag");
            chk(16'(n_hold), 16'(k[0]), "hold count");
            if (n_hold == 1) chk_t(t_hold, t_cv + 120, "hold pulse");
            cvsc_host_model_i.read_reg(5'h07, rv);
            chk(rv, cfg(1'b1, 5'h00, 3'(k), k[0]) | 16'(exp_slot) << 4, "readback");
        end
        cvsc_host_model_i.write_reg(5'h07, cfg(1'b0, 5'h00, 3'h1, 1'b1));
        pulse(3);
        // The monitor still sees the old flag at the clearing edge, so rearm after it.
        #1;
        chk(16'(flag), 16'h0000, "flag cleared when off");
        t_flag = -1;
        send_cv(outv(), 1'b0);
        repeat (3) @(posedge clk);
        chk_t(t_flag, -1, "no flag when off");
        $display("stall test done");
        wrap_up();
    end
endmodule
